// ---- core/status_byte_service_request.sv ----
`timescale 1ns/10ps
module status_byte_service_request
  import sbsr_pkg::*;
(
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         reset_n_i,
  // summary messages
  input  wire summary_t                     summary_i,
  // enable mask programming
  input  wire logic                         sre_write_i,
  input  wire logic [SB_W-1:0]              sre_data_i,
  // queries
  input  wire logic                         stb_query_i,
  input  wire logic                         sre_query_i,
  input  wire logic                         reg_query_i,
  input  wire logic [REG_W-1:0]             reg_query_value_i,
  input  wire logic                         reg_query_clears_i,
  // serial poll
  input  wire logic                         serial_poll_i,
  // service request and status
  output logic                              service_request_o,
  output logic [SB_W-1:0]                   status_byte_o,
  // serial poll answer
  output logic                              poll_valid_o,
  output logic [SB_W-1:0]                   poll_byte_o,
  // query answer
  output logic                              query_busy_o,
  output logic                              resp_valid_o,
  output logic [REG_W-1:0]                  resp_value_o,
  output logic [BCD_DIGITS*DIGIT_W-1:0]     resp_bcd_o,
  output logic                              event_clear_o
);

  // =========================================================
  // reset release through two flops
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // =========================================================
  // summary gathering and master summary
  logic [SB_W-1:0] request_enable_mask;
  logic [SB_W-1:0] summary_now;
  logic [SB_W-1:0] enabled_now;
  logic [SB_W-1:0] enabled_prev;
  logic            master_summary;
  logic            enable_rise;
  logic [SB_W-1:0] stb_now;

  // summaries pass straight through, nothing here holds them
  assign summary_now    = summary_bits(summary_i);
  assign enabled_now    = summary_now & request_enable_mask;
  assign master_summary = |enabled_now;
  assign enable_rise    = |(enabled_now & ~enabled_prev);

  // query view carries master summary in B6
  always_comb begin
    stb_now            = summary_now;
    stb_now[SB_MASTER] = master_summary;
  end

  // =========================================================
  // enable mask; only its own write reaches it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      request_enable_mask <= SRE_RESET;
    end else if (sre_write_i) begin
      // unused lanes are dropped so they read back zero
      request_enable_mask <= sre_data_i & SRE_WRITABLE;
    end
  end

  // =========================================================
  // request flag; a new rise wins over the poll's clear
  logic request_service_flag;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      enabled_prev         <= SB_ZERO;
      request_service_flag <= 1'b0;
    end else begin
      enabled_prev <= enabled_now;
      if (enable_rise) begin
        request_service_flag <= 1'b1;
      end else if (serial_poll_i) begin
        request_service_flag <= 1'b0;
      end
    end
  end

  // the pin is the flag itself, so no extra lag
  assign service_request_o = request_service_flag;

  // =========================================================
  // live status byte, one register stage behind the inputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status_byte_o <= SB_ZERO;
    end else begin
      status_byte_o <= stb_now;
    end
  end

  // =========================================================
  // serial poll answer shows the flag before the poll clears it
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      poll_valid_o <= 1'b0;
      poll_byte_o  <= SB_ZERO;
    end else begin
      poll_valid_o <= serial_poll_i;
      if (serial_poll_i) begin
        poll_byte_o            <= summary_now;
        poll_byte_o[SB_MASTER] <= request_service_flag;
      end
    end
  end

  // =========================================================
  // query selection: stb over sre over other registers
  logic             accept;
  logic             sel_reg;
  logic [REG_W-1:0] query_value;
  logic [REG_W-1:0] held_value;
  logic             fmt_done;
  logic [BCD_DIGITS*DIGIT_W-1:0] fmt_bcd;

  // queries arriving while one is in flight are ignored
  assign accept  = (stb_query_i | sre_query_i | reg_query_i) & ~query_busy_o;
  assign sel_reg = ~stb_query_i & ~sre_query_i;

  always_comb begin
    if (stb_query_i) begin
      query_value = {{(REG_W-SB_W){1'b0}}, stb_now};
    end else if (sre_query_i) begin
      query_value = {{(REG_W-SB_W){1'b0}}, request_enable_mask};
    end else begin
      query_value = reg_query_value_i & REG_MASK;
    end
  end

  // busy from accept until the answer is posted
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      query_busy_o  <= 1'b0;
      held_value    <= '0;
      event_clear_o <= 1'b0;
    end else begin
      event_clear_o <= accept & sel_reg & reg_query_clears_i;
      if (accept) begin
        query_busy_o <= 1'b1;
        held_value   <= query_value;
      end else if (fmt_done) begin
        query_busy_o <= 1'b0;
      end
    end
  end

  // =========================================================
  // binary to decimal digits for the response text
  decimal_formatter #(
    .VALUE_W (REG_W),
    .DIGITS  (BCD_DIGITS)
  ) u_fmt (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .start_i (accept),
    .value_i (query_value),
    .done_o  (fmt_done),
    .bcd_o   (fmt_bcd)
  );

  // answer posted as a one-cycle pulse, value held until the next
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid_o <= 1'b0;
      resp_value_o <= '0;
      resp_bcd_o   <= '0;
    end else begin
      resp_valid_o <= fmt_done;
      if (fmt_done) begin
        resp_value_o <= held_value;
        resp_bcd_o   <= fmt_bcd;
      end
    end
  end

  // =========================================================
  // checks
  localparam int FMT_MAX = 24;

  sequence seq_enable_rise;
    enable_rise;
  endsequence

  sequence seq_quiet_poll;
    serial_poll_i && !enable_rise;
  endsequence

  // neither a new rise nor a poll: the flag has no reason to move
  sequence seq_quiet_cycle;
    !enable_rise && !serial_poll_i;
  endsequence

  a_mask_zero_write: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    sre_write_i && sre_data_i == SB_ZERO |=> request_enable_mask == SB_ZERO)
    else $error("enable mask not cleared by zero write");

  a_mask_store: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    sre_write_i |=> request_enable_mask == ($past(sre_data_i) & SRE_WRITABLE))
    else $error("enable mask did not store written value");

  a_rise_requests: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    seq_enable_rise |=> service_request_o)
    else $error("enabled rise did not raise service request");

  a_poll_clears: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    seq_quiet_poll |=> !service_request_o)
    else $error("serial poll did not clear request flag");

  // mask lane B6 is never writable, so the byte's own B6 drops out of the OR
  a_master_kept: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    serial_poll_i
      |=> status_byte_o[SB_MASTER] == |(status_byte_o & $past(request_enable_mask)))
    else $error("master summary lost on serial poll");

  a_unused_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !status_byte_o[SB_UNUSED] && !request_enable_mask[SB_UNUSED]
      && !request_enable_mask[SB_MASTER])
    else $error("unused status bit not zero");

  a_byte_follows: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    ##1 status_byte_o == ($past(summary_now) | ({7'h00, $past(master_summary)} << SB_MASTER)))
    else $error("status byte does not follow summaries");

  a_poll_b6_flag: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    serial_poll_i |=> poll_valid_o && poll_byte_o[SB_MASTER] == $past(request_service_flag))
    else $error("poll byte B6 is not the request flag");

  a_query_answer: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    accept |-> ##[1:FMT_MAX] resp_valid_o)
    else $error("query answer not posted in time");

  a_event_clear: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    accept && sel_reg && reg_query_clears_i |=> event_clear_o)
    else $error("standard event read did not clear");

  a_top_bit_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !resp_value_o[REG_TOP])
    else $error("top bit of register answer not zero");

  // a spurious request would wake the controller for nothing
  a_no_false_request: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !enable_rise && !service_request_o |=> !service_request_o)
    else $error("service request raised without an enabled rise");

  a_flag_steady: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    seq_quiet_cycle |=> $stable(service_request_o))
    else $error("request flag moved with no rise and no poll");

  a_poll_summaries: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    serial_poll_i |=> poll_byte_o[SB_OPER] == $past(summary_now[SB_OPER])
      && poll_byte_o[SB_STD:SB_MEAS] == $past(summary_now[SB_STD:SB_MEAS]))
    else $error("poll byte does not carry the summaries");

  a_poll_unused_zero: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    !poll_byte_o[SB_UNUSED])
    else $error("unused bit set in poll byte");

  // a query landing while busy must not disturb the one in flight
  a_query_refused: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    query_busy_o && !fmt_done |=> query_busy_o && $stable(held_value))
    else $error("query accepted while another was in flight");

  a_busy_release: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    fmt_done |=> resp_valid_o && !query_busy_o)
    else $error("answer not posted or busy not released");

  a_stb_master: assert property (
    @(posedge clk_i) disable iff (!rst_n)
    accept && stb_query_i
      |=> held_value[SB_MASTER] == |$past(summary_now & request_enable_mask))
    else $error("status byte query B6 is not the master summary");

endmodule : status_byte_service_request

// ---- core/sbsr_pkg.sv ----
// Operation
// - summary bits follow their inputs, never latch
// - B0 measurement summary, B1 unused
// - B2 set while error queue nonempty
// - B3 carries questionable summary
// - B4 set while output queue nonempty
// - B5 carries standard event summary
// - B7 carries operation summary
// - B6 is OR of enabled summary bits
// - B6 is flag on poll, master on query
// - enable mask written, stored and read back
// - enable mask zero at power-up and on zero write
// - clear and preset commands leave mask alone
// - enabled summary rising edge raises service request
// - serial poll clears flag; later edges re-request
// - serial poll never clears master summary
// - standard event read clears it, dropping B5
// - queries answer as unsigned decimal number
// - bit B15 of status registers reads zero
// - serial poll answered with the status byte
// - everything starts cleared at power-up
package sbsr_pkg;

  // =========================================================
  // widths
  localparam int SB_W       = 8;
  localparam int REG_W      = 16;
  localparam int BCD_DIGITS = 5;
  localparam int DIGIT_W    = 4;

  // =========================================================
  // status byte bit positions
  localparam int SB_MEAS   = 0;
  localparam int SB_UNUSED = 1;
  localparam int SB_ERR    = 2;
  localparam int SB_QUES   = 3;
  localparam int SB_OUTQ   = 4;
  localparam int SB_STD    = 5;
  localparam int SB_MASTER = 6;
  localparam int SB_OPER   = 7;
  localparam int REG_TOP   = 15;

  // =========================================================
  // reset values and masks
  localparam logic [SB_W-1:0]  SRE_RESET    = 8'h00;
  localparam logic [SB_W-1:0]  SRE_WRITABLE = 8'hbd;
  localparam logic [REG_W-1:0] REG_MASK     = 16'h7fff;
  localparam logic [SB_W-1:0]  SB_ZERO      = 8'h00;

  // decimal conversion constants
  localparam logic [DIGIT_W-1:0] BCD_ADJ_AT  = 4'h5;
  localparam logic [DIGIT_W-1:0] BCD_ADJ_ADD = 4'h3;

  // =========================================================
  // summary messages from the event sets and queues
  typedef struct packed {
    logic operation_summary;
    logic standard_event_summary;
    logic output_queue_nonempty;
    logic questionable_summary;
    logic error_queue_nonempty;
    logic measurement_summary;
  } summary_t;

  // formatter states
  typedef enum logic [1:0] {
    FMT_IDLE  = 2'h1,
    FMT_SHIFT = 2'h2
  } fmt_state_t;

  // place summaries into status byte lanes, B1 and B6 left zero
  function automatic logic [SB_W-1:0] summary_bits(input summary_t s);
    logic [SB_W-1:0] b;
    b          = SB_ZERO;
    b[SB_MEAS] = s.measurement_summary;
    b[SB_ERR]  = s.error_queue_nonempty;
    b[SB_QUES] = s.questionable_summary;
    b[SB_OUTQ] = s.output_queue_nonempty;
    b[SB_STD]  = s.standard_event_summary;
    b[SB_OPER] = s.operation_summary;
    return b;
  endfunction : summary_bits

endpackage : sbsr_pkg

// ---- core/decimal_formatter.sv ----
`timescale 1ns/10ps
module decimal_formatter
  import sbsr_pkg::*;
#(
  parameter int VALUE_W = REG_W,
  parameter int DIGITS  = BCD_DIGITS
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  // request
  input  wire logic                  start_i,
  input  wire logic [VALUE_W-1:0]    value_i,
  // answer
  output logic                       done_o,
  output logic [DIGITS*DIGIT_W-1:0]  bcd_o
);

  localparam int BCD_W  = DIGITS * DIGIT_W;
  localparam int WORK_W = BCD_W + VALUE_W;
  localparam int CNT_W  = $clog2(VALUE_W + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(VALUE_W - 1);

  fmt_state_t         state;
  logic [WORK_W-1:0]  work;
  logic [CNT_W-1:0]   cnt;
  logic [BCD_W-1:0]   adj_bcd;
  logic [WORK_W-1:0]  next_work;

  // =========================================================
  // add-three correction on every digit before each shift
  for (genvar d = 0; d < DIGITS; d++) begin : g_adj
    logic [DIGIT_W-1:0] digit;
    assign digit = work[VALUE_W + d*DIGIT_W +: DIGIT_W];
    assign adj_bcd[d*DIGIT_W +: DIGIT_W] =
      (digit >= BCD_ADJ_AT) ? digit + BCD_ADJ_ADD : digit;
  end

  // shift left one binary place through the digit field
  assign next_work = {adj_bcd[BCD_W-2:0], work[VALUE_W-1:0], 1'b0};

  // =========================================================
  // one bit per cycle keeps the logic small at the cost of latency
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= FMT_IDLE;
      work   <= '0;
      cnt    <= '0;
      done_o <= 1'b0;
      bcd_o  <= '0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        FMT_IDLE: begin
          if (start_i) begin
            work  <= {{BCD_W{1'b0}}, value_i};
            cnt   <= '0;
            state <= FMT_SHIFT;
          end
        end
        FMT_SHIFT: begin
          work <= next_work;
          cnt  <= cnt + 1'b1;
          if (cnt == LAST) begin
            state  <= FMT_IDLE;
            done_o <= 1'b1;
            bcd_o  <= next_work[WORK_W-1:VALUE_W];
          end
        end
        default: begin
          state <= FMT_IDLE;
        end
      endcase
    end
  end

endmodule : decimal_formatter

// ---- sim/poll_controller.sv ----
`timescale 1ns/10ps
// ==========================================================
// bus controller side: reads the serial poll byte on demand
module poll_controller
  import sbsr_pkg::*;
(
  // clock
  input  wire logic            clk_i,
  // poll handshake
  output logic                 serial_poll_o,
  input  wire logic            poll_valid_i,
  input  wire logic [SB_W-1:0] poll_byte_i
);
  // no poll outstanding until the bench asks for one
  initial serial_poll_o = 1'b0;

  // one poll byte read; gap lets the controller be slow to react
  task automatic poll(input int gap, output logic [SB_W-1:0] pb, output bit ok);
    int n;
    ok = 1'b0;
    pb = SB_ZERO;
    repeat (gap) @(negedge clk_i);
    serial_poll_o = 1'b1;
    @(negedge clk_i);
    serial_poll_o = 1'b0;
    // bounded wait: a device that never answers must not hang the run
    for (n = 0; n < 4 && !ok; n++) begin
      if (poll_valid_i === 1'b1) begin
        pb = poll_byte_i;
        ok = 1'b1;
      end else begin
        @(negedge clk_i);
      end
    end
  endtask : poll
endmodule : poll_controller

// ---- sim/status_byte_service_request_bench.sv ----
`timescale 1ns/10ps
// ==========================================================
// self-checking bench for the status byte and service request
module status_byte_service_request_bench
  import sbsr_pkg::*;
;
  logic                          clk_i = 1'b0;
  logic                          reset_n_i = 1'b0;
  summary_t                      summary = '0;
  logic                          sre_write = 1'b0;
  logic [SB_W-1:0]               sre_data = 8'h00;
  logic                          stb_query = 1'b0;
  logic                          sre_query = 1'b0;
  logic                          reg_query = 1'b0;
  logic [REG_W-1:0]              reg_value = 16'h0000;
  logic                          reg_clears = 1'b0;
  logic                          serial_poll;
  logic                          service_request_o;
  logic [SB_W-1:0]               status_byte_o;
  logic                          poll_valid_o;
  logic                          query_busy_o;
  logic [SB_W-1:0]               poll_byte_o;
  logic                          resp_valid_o;
  logic [REG_W-1:0]              resp_value_o;
  logic [BCD_DIGITS*DIGIT_W-1:0] resp_bcd_o;
  logic                          event_clear_o;
  logic [SB_W-1:0]               pb;
  int                            fail_count = 0;
  int                            total_checks = 0;
  int                            lane [6] = '{0, 2, 3, 4, 5, 7};
  bit                            ok;
  bit                            clr;

  // ========================================================
  // clock, design and far side
  always #50 clk_i = ~clk_i;

  status_byte_service_request dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .summary_i(summary),
    .sre_write_i(sre_write), .sre_data_i(sre_data), .stb_query_i(stb_query),
    .sre_query_i(sre_query), .reg_query_i(reg_query), .reg_query_value_i(reg_value),
    .reg_query_clears_i(reg_clears), .serial_poll_i(serial_poll),
    .service_request_o(service_request_o), .status_byte_o(status_byte_o),
    .poll_valid_o(poll_valid_o), .poll_byte_o(poll_byte_o), .query_busy_o(query_busy_o),
    .resp_valid_o(resp_valid_o), .resp_value_o(resp_value_o), .resp_bcd_o(resp_bcd_o),
    .event_clear_o(event_clear_o));

  poll_controller ctrl_u (
    .clk_i(clk_i), .serial_poll_o(serial_poll),
    .poll_valid_i(poll_valid_o), .poll_byte_i(poll_byte_o));

  // ========================================================
  // helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // decimal digits worked out independently of the design
  function automatic logic [19:0] to_bcd(input logic [REG_W-1:0] v);
    int x;
    x = int'(v);
    for (int i = 0; i < 5; i++) begin
      to_bcd[i*4 +: 4] = 4'(x % 10);
      x = x / 10;
    end
  endfunction : to_bcd

  task automatic sre_wr(input logic [SB_W-1:0] d);
    @(negedge clk_i);
    sre_write = 1'b1;
    sre_data = d;
    @(negedge clk_i);
    sre_write = 1'b0;
  endtask : sre_wr

  // kind 0 status byte, 1 enable mask, 2 outside register
  task automatic query(input int kind, input logic [REG_W-1:0] exp, output bit clr_seen);
    bit got;
    got = 1'b0;
    clr_seen = 1'b0;
    @(negedge clk_i);
    stb_query = (kind == 0);
    sre_query = (kind == 1);
    reg_query = (kind == 2);
    @(negedge clk_i);
    {stb_query, sre_query, reg_query} = 3'b000;
    check(query_busy_o, 1'b1);
    for (int n = 0; n < 30 && !got; n++) begin
      if (event_clear_o === 1'b1) clr_seen = 1'b1;
      if (resp_valid_o === 1'b1) got = 1'b1;
      else @(negedge clk_i);
    end
    if (!got) begin
      fail_count++;
      complete_run();
    end
    check(resp_value_o, exp);
    check(resp_bcd_o, to_bcd(exp));
    check(query_busy_o, 1'b0);
  endtask : query

  task automatic do_poll(input int gap);
    ctrl_u.poll(gap, pb, ok);
    if (!ok) begin
      fail_count++;
      complete_run();
    end
  endtask : do_poll

  // ========================================================
  // main sequence
  initial begin
    logic [SB_W-1:0] sb;
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    check(service_request_o, 1'b0);
    query(1, 16'h0000, clr);
    query(0, 16'h0000, clr);
    $display("test power-up done");

    sre_wr(8'hff);
    query(1, 16'h00bd, clr);
    sre_wr(8'h00);
    query(1, 16'h0000, clr);
    $display("test enable mask done");

    // each summary lane alone: request, poll, master summary, fall
    for (int k = 0; k < 6; k++) begin
      sb = 8'h01 << lane[k];
      sre_wr(sb);
      summary = summary_t'(6'h01 << k);
      repeat (2) @(negedge clk_i);
      check(service_request_o, 1'b1);
      check(status_byte_o, sb | 8'h40);
      do_poll(k);
      check(pb, sb | 8'h40);
      check(service_request_o, 1'b0);
      check(status_byte_o, sb | 8'h40);
      query(0, {8'h00, sb | 8'h40}, clr);
      summary = '0;
      repeat (2) @(negedge clk_i);
      check(status_byte_o, 8'h00);
    end
    $display("test summary lanes done");

    // disabled lane sets its bit but never the master summary
    sre_wr(8'h00);
    summary = summary_t'(6'h08);
    repeat (2) @(negedge clk_i);
    check(status_byte_o, 8'h10);
    check(service_request_o, 1'b0);
    $display("test disabled lane done");

    // a second enabled rise after a poll raises a new request
    sre_wr(8'hbd);
    summary = summary_t'(6'h01);
    repeat (2) @(negedge clk_i);
    do_poll(0);
    summary = summary_t'(6'h03);
    repeat (2) @(negedge clk_i);
    check(service_request_o, 1'b1);
    summary = summary_t'(6'h01);
    repeat (2) @(negedge clk_i);
    check(status_byte_o, 8'h41);
    summary = '0;
    repeat (2) @(negedge clk_i);
    check(status_byte_o, 8'h00);
    $display("test re-request done");

    // outside register queries: top bit masked, clear on read
    reg_value = 16'hffff;
    reg_clears = 1'b1;
    query(2, 16'h7fff, clr);
    check(clr, 1'b1);
    reg_value = 16'h0013;
    reg_clears = 1'b0;
    query(2, 16'h0013, clr);
    check(clr, 1'b0);
    $display("test register queries done");

    // a query raised while one is in flight gets no answer of its own
    @(negedge clk_i);
    sre_query = 1'b1;
    @(negedge clk_i);
    sre_query = 1'b0;
    stb_query = 1'b1;
    @(negedge clk_i);
    stb_query = 1'b0;
    repeat (20) @(negedge clk_i);
    check(resp_value_o, 16'h00bd);
    check(resp_bcd_o, to_bcd(16'h00bd));
    check(query_busy_o, 1'b0);
    $display("test busy refusal done");
    complete_run();
  end
endmodule : status_byte_service_request_bench
